// >>> design/tx_slot_map.sv
// Purpose: Transmit slot mapping of output channels 6 and 7
// Assumes: Bit clock and frame sync from the bus, 32-bit slots, MSB first
// Notes:   Loopback and sensor words are sampled at a rising frame sync (right half start in LR)
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "slot_map_cfg.svh"
module tx_slot_map (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        bit_clock,
    input  wire logic        frame_sync,
    input  wire logic [31:0] loopback_ch2_word,
    input  wire logic [15:0] battery_voltage_half_word,
    input  wire logic [15:0] temperature_half_word,
    output logic             serial_data_out,
    output logic             serial_data_oe
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic bclk_rise;
    logic fs_level;

    edge_sync u_bclk_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (bit_clock),
        .level    (),
        .rise     (bclk_rise),
        .fall     ()
    );

    // Frame sync is sampled, not edge-timed, so use its level at bit clock rise
    edge_sync u_fs_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (frame_sync),
        .level    (fs_level),
        .rise     (),
        .fall     ()
    );

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [6:0] ch6_cfg_reg;
    logic [6:0] ch6_cfg_next;
    logic [6:0] ch7_cfg_reg;
    logic [6:0] ch7_cfg_next;
    logic       fmt_reg;
    logic       fmt_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb begin
        ch6_cfg_next = ch6_cfg_reg;
        ch7_cfg_next = ch7_cfg_reg;
        fmt_next     = fmt_reg;
        rdata_next   = 8'h00;
        if (reg_wr) begin
            // Bit 7 is not stored, so it always reads back as zero
            unique case (reg_addr)
                `CH6_CFG_ADDR: ch6_cfg_next = reg_wdata[6:0];
                `CH7_CFG_ADDR: ch7_cfg_next = reg_wdata[6:0];
                `FMT_CFG_ADDR: fmt_next     = reg_wdata[0];
                default:       ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `CH6_CFG_ADDR: rdata_next = {1'b0, ch6_cfg_reg};
                `CH7_CFG_ADDR: rdata_next = {1'b0, ch7_cfg_reg};
                `FMT_CFG_ADDR: rdata_next = {7'h00, fmt_reg};
                default:       rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Bit 7 of the reset value is zero and is not stored
            ch6_cfg_reg <= 7'(`CH6_CFG_RESET);
            ch7_cfg_reg <= 7'(`CH7_CFG_RESET);
            fmt_reg     <= 1'b0;
            rdata_reg   <= 8'h00;
        end else begin
            ch6_cfg_reg <= ch6_cfg_next;
            ch7_cfg_reg <= ch7_cfg_next;
            fmt_reg     <= fmt_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ----------------------------------------
    // Slot and bit counters
    // ----------------------------------------
    // Frame start is a rising frame sync seen at a bit clock rise (TDM),
    // or either frame sync edge for the two-half (LR) format.
    logic                      fs_prev_reg;
    logic                      fs_prev_next;
    logic [`WORD_CNT_W-1:0]    bit_reg;
    logic [`WORD_CNT_W-1:0]    bit_next;
    logic [`SLOT_CNT_W-1:0]    slot_reg;
    logic [`SLOT_CNT_W-1:0]    slot_next;
    logic                      right_reg;
    logic                      right_next;
    logic                      run_reg;
    logic                      run_next;
    logic [31:0]               ch6_word_reg;
    logic [31:0]               ch6_word_next;
    logic [31:0]               ch7_word_reg;
    logic [31:0]               ch7_word_next;
    logic                      frame_start;
    logic                      half_start;
    slot_map_pkg::frame_format_t fmt;

    assign fmt         = slot_map_pkg::frame_format_t'(fmt_reg);
    assign frame_start = bclk_rise & fs_level & ~fs_prev_reg;
    assign half_start  = bclk_rise & (fs_level ^ fs_prev_reg);

    always_comb begin
        fs_prev_next  = fs_prev_reg;
        bit_next      = bit_reg;
        slot_next     = slot_reg;
        right_next    = right_reg;
        run_next      = run_reg;
        ch6_word_next = ch6_word_reg;
        ch7_word_next = ch7_word_reg;
        if (bclk_rise) begin
            fs_prev_next = fs_level;
            if ((fmt == slot_map_pkg::FMT_TDM) ? frame_start : half_start) begin
                bit_next   = '0;
                slot_next  = '0;
                // Low frame sync marks the left half, high the right half
                right_next = (fmt == slot_map_pkg::FMT_LR) & fs_level;
                run_next   = 1'b1;
                if (frame_start) begin
                    ch6_word_next = loopback_ch2_word;
                    ch7_word_next = {battery_voltage_half_word,
                                     temperature_half_word};
                end
            end else if (run_reg) begin
                bit_next = bit_reg + 1'b1;
                if (bit_reg == `WORD_CNT_W'(`WORD_BITS - 1)) begin
                    slot_next = slot_reg + 1'b1;
                    // Slots past 31 in TDM are never owned
                    if (slot_reg == '1) begin
                        run_next = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fs_prev_reg  <= 1'b0;
            bit_reg      <= '0;
            slot_reg     <= '0;
            right_reg    <= 1'b0;
            run_reg      <= 1'b0;
            ch6_word_reg <= 32'h0000_0000;
            ch7_word_reg <= 32'h0000_0000;
        end else begin
            fs_prev_reg  <= fs_prev_next;
            bit_reg      <= bit_next;
            slot_reg     <= slot_next;
            right_reg    <= right_next;
            run_reg      <= run_next;
            ch6_word_reg <= ch6_word_next;
            ch7_word_reg <= ch7_word_next;
        end
    end

    // ----------------------------------------
    // Slot match and output drive
    // ----------------------------------------
    logic [1:0] owns;
    logic [1:0] enabled;
    logic [6:0] cfg [2];
    logic [31:0] word [2];

    assign cfg[0]  = ch6_cfg_reg;
    assign cfg[1]  = ch7_cfg_reg;
    // Match on the counts that the coming bit will carry; the registered
    // counts still describe the previous bit and would shift the slot by one
    // bit. The frame's first bit also needs the word captured at that rise.
    assign word[0] = ch6_word_next;
    assign word[1] = ch7_word_next;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [4:0] slot_val;
        assign slot_val   = cfg[c][`SLOT_MSB:`SLOT_LSB];
        // Unused source codes behave as tri-state
        assign enabled[c] = cfg[c][`SRC_MSB:`SRC_LSB] == `SRC_ACTIVE;
        always_comb begin
            if (fmt == slot_map_pkg::FMT_TDM) begin
                owns[c] = enabled[c] & run_next & (slot_val == slot_next);
            end else begin
                owns[c] = enabled[c] & run_next
                        & (slot_val[`HALF_SLOT_BIT] == right_next)
                        & (slot_val[3:0] == slot_next[3:0])
                        & ~slot_next[4];
            end
        end
    end

    logic out_reg;
    logic out_next;
    logic oe_reg;
    logic oe_next;

    // Ch6 wins if both channels claim the same slot
    always_comb begin
        out_next = out_reg;
        oe_next  = oe_reg;
        if (bclk_rise) begin
            oe_next = |owns;
            if (owns[0]) begin
                out_next = word[0][5'd31 - bit_next];
            end else if (owns[1]) begin
                out_next = word[1][5'd31 - bit_next];
            end else begin
                out_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end else begin
            out_reg <= out_next;
            oe_reg  <= oe_next;
        end
    end

    assign serial_data_out = out_reg;
    assign serial_data_oe  = oe_reg;
endmodule : tx_slot_map
`default_nettype wire

// >>> shared/slot_map_cfg.svh
// Purpose: Offsets, fields, reset values and timing counts for the ch6/ch7 slot mapper
// Assumes: 8-bit register port, 100 MHz clk
// Notes:   Definitions only
`ifndef SLOT_MAP_CFG_SVH
`define SLOT_MAP_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CH6_CFG_ADDR        8'h23
`define CH7_CFG_ADDR        8'h24
`define FMT_CFG_ADDR        8'h25

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SRC_MSB             6
`define SRC_LSB             5
`define SLOT_MSB            4
`define SLOT_LSB            0
`define HALF_SLOT_BIT       4
`define CH6_CFG_RESET       8'h05
`define CH7_CFG_RESET       8'h06
`define FMT_CFG_RESET       8'h00
`define SRC_TRISTATE        2'h0
`define SRC_ACTIVE          2'h1
`define WORD_BITS           32
`define WORD_CNT_W          5
`define SLOT_CNT_W          5

`endif

// >>> shared/slot_map_pkg.sv
// Purpose: Types for the ch6/ch7 slot mapper
// Assumes: Constants come from slot_map_cfg.svh
// Notes:   Types only
`default_nettype none
package slot_map_pkg;
    typedef enum logic [0:0] {
        FMT_TDM     = 1'h0,
        FMT_LR      = 1'h1
    } frame_format_t;
endpackage : slot_map_pkg
`default_nettype wire

// >>> design/edge_sync.sv
// Purpose: Two-flop synchroniser with rise and fall pulses
// Assumes: Input is asynchronous to clk
// Notes:   Edges are detected on the second stage only
`timescale 1ns/10ps
`default_nettype none
module edge_sync (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic [2:0] pipe_reg;
    logic [2:0] pipe_next;

    always_comb begin
        pipe_next = {pipe_reg[1:0], async_in};
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pipe_reg <= 3'h0;
        end else begin
            pipe_reg <= pipe_next;
        end
    end

    assign level = pipe_reg[1];
    assign rise  = pipe_reg[1] & ~pipe_reg[2];
    assign fall  = ~pipe_reg[1] & pipe_reg[2];
endmodule : edge_sync
`default_nettype wire

// >>> bench/tx_slot_map_chk.sv
// Purpose: Port checks for tx_slot_map
// Assumes: Shadow copies of the channel registers follow the write port
// Notes:   Bind statement at the foot
`timescale 1ns/10ps
`default_nettype none
`include "slot_map_cfg.svh"
module tx_slot_map_chk (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       bit_clock,
    input wire logic       serial_data_out,
    input wire logic       serial_data_oe
);
    logic [7:0] sh6_reg;
    logic [7:0] sh7_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sh6_reg <= `CH6_CFG_RESET;
            sh7_reg <= `CH7_CFG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `CH6_CFG_ADDR) sh6_reg <= {1'b0, reg_wdata[6:0]};
            if (reg_addr == `CH7_CFG_ADDR) sh7_reg <= {1'b0, reg_wdata[6:0]};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence rd_of(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence slot_start;
        $rose(serial_data_oe);
    endsequence
    chk_ch6_readback: assert property (rd_of(`CH6_CFG_ADDR) |=> reg_rdata == sh6_reg)
        else $error("ch6 readback differs");
    chk_ch7_readback: assert property (rd_of(`CH7_CFG_ADDR) |=> reg_rdata == sh7_reg)
        else $error("ch7 readback differs");
    chk_bit7_zero: assert property ($past(reg_rd) |-> !reg_rdata[7])
        else $error("bit 7 read as one");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    // Sources other than one never own a slot
    chk_rise_owned: assert property (slot_start |-> sh6_reg[6:5] == 2'h1 || sh7_reg[6:5] == 2'h1)
        else $error("drive with no active source");
    chk_oe_hold: assert property (slot_start |=> serial_data_oe [*8])
        else $error("drive dropped early");
    chk_rise_bclk: assert property (slot_start |-> $past(bit_clock, 2))
        else $error("drive not after a bit clock rise");
    chk_data_steady: assert property ($changed(serial_data_out) && serial_data_oe &&
        $past(serial_data_oe) |-> $past(bit_clock, 2))
        else $error("data moved away from a bit clock rise");
endmodule : tx_slot_map_chk
bind tx_slot_map tx_slot_map_chk u_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bit_clock(bit_clock), .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));
`default_nettype wire

// >>> bench/host_link_model.sv
// Purpose: Host end of the serial bus: bit clock, frame sync, capture
// Assumes: 160 ns bit clock, 1024 bits a frame, free running
// Notes:   Samples on the falling bit clock edge, well after the data settles
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
    input  wire logic lr,
    input  wire logic sdo,
    input  wire logic oe,
    output logic      bclk,
    output logic      fs
);
    logic [1023:0] dat;
    logic [1023:0] en;
    int            idx;
    int            frames;
    initial begin
        bclk = 1'b0;
        fs = 1'b0;
        idx = 0;
        frames = 0;
        #3;
        forever begin
            fs = lr ? (idx >= 512) : (idx == 0);
            #80 bclk = 1'b1;
            #80 bclk = 1'b0;
            // A released line reads as the inverse, so stray captures show
            dat[idx] = oe ? sdo : ~sdo;
            en[idx] = oe;
            idx = (idx + 1) % 1024;
            if (idx == 0) frames++;
        end
    end
endmodule : host_link_model
`default_nettype wire

// >>> bench/tb_top.sv
// Purpose: Self-checking bench for tx_slot_map
// Assumes: Host model makes the bit clock and frame sync
// Notes:   Config goes in early in a frame, the next whole frame is judged
`timescale 1ns/10ps
`default_nettype none
`include "slot_map_cfg.svh"
module tb_top;
    localparam logic [31:0] LB_WORD = 32'hA5C30F96;
    localparam logic [31:0] SN_WORD = 32'h1234FE01;
    logic       clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, lr = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic       bit_clock, frame_sync, serial_data_out, serial_data_oe;
    int         error_cnt = 0, tests_run = 0;
    always #5 clk = ~clk;
    tx_slot_map u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bit_clock(bit_clock), .frame_sync(frame_sync), .loopback_ch2_word(LB_WORD),
        .battery_voltage_half_word(SN_WORD[31:16]), .temperature_half_word(SN_WORD[15:0]),
        .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));
    host_link_model u_host (.lr(lr), .sdo(serial_data_out), .oe(serial_data_oe),
        .bclk(bit_clock), .fs(frame_sync));
    task automatic print_verdict;
        $display("compares %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : check_reg
    task automatic check_vec(input logic [1023:0] got, input logic [1023:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : check_vec
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check_reg(reg_rdata, exp);
    endtask : read_check
    // Bounded wait for a frame count and a bit window of the host
    task automatic wait_host(input int f, input int b);
        int n;
        for (n = 0; n < 40000; n++) begin
            if (u_host.frames >= f && u_host.idx >= b && u_host.idx < b + 16) break;
            @(posedge clk);
        end
        if (n == 40000) begin
            error_cnt++;
            print_verdict();
        end
    endtask : wait_host
    // Writing in the first bits of a frame keeps the next frame clean of
    // mid-frame changes and keeps the run short
    task automatic frame_test(input logic [7:0] c6, input logic [7:0] c7,
                              input logic [7:0] fmt, input int s6, input int s7);
        logic [1023:0] ee;
        logic [1023:0] ed;
        int            f;
        ee = '0;
        ed = '0;
        wait_host(0, 0);
        f = u_host.frames;
        reg_write(`CH6_CFG_ADDR, c6);
        reg_write(`CH7_CFG_ADDR, c7);
        reg_write(`FMT_CFG_ADDR, fmt);
        lr <= fmt[0];
        wait_host(f + 2, 0);
        for (int i = 0; i < 32; i++) begin
            if (s6 >= 0) ee[s6 * 32 + i] = 1'b1;
            if (s6 >= 0) ed[s6 * 32 + i] = LB_WORD[31 - i];
            if (s7 >= 0) ee[s7 * 32 + i] = 1'b1;
            if (s7 >= 0) ed[s7 * 32 + i] = SN_WORD[31 - i];
        end
        check_vec(u_host.en, ee);
        check_vec(u_host.dat & ee, ed);
    endtask : frame_test
    task automatic reg_test;
        read_check(`CH6_CFG_ADDR, `CH6_CFG_RESET);
        read_check(`CH7_CFG_ADDR, `CH7_CFG_RESET);
        reg_write(`CH7_CFG_ADDR, 8'h7F);
        read_check(`CH7_CFG_ADDR, 8'h7F);
        reg_write(8'h26, 8'h55);
        read_check(8'h26, 8'h00);
    endtask : reg_test
    task automatic tdm_default;
        frame_test(8'h25, 8'h26, 8'h00, 5, 6);
    endtask : tdm_default
    task automatic tdm_edges;
        frame_test(8'h3F, 8'h40, 8'h00, 31, -1);
    endtask : tdm_edges
    task automatic lr_halves;
        frame_test(8'h30, 8'h2F, 8'h01, 16, 15);
    endtask : lr_halves
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        reg_test();
        tdm_default();
        tdm_edges();
        lr_halves();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
